// >>> rtl/gds_spi_regs.sv
`timescale 1ns/1ps
`include "gds_params.svh"

module gds_spi_regs
    import gds_pkg::*;
#(
    parameter bit HAS_SENSE_AMP = 1'b1
) (
    // system clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       arst_n_in,
    // serial link
    input  wire logic       serial_clk_in,
    input  wire logic       chip_select_n_in,
    input  wire logic       serial_in_in,
    output logic            serial_out_out,
    output logic            serial_out_oe_out,
    // fault pin, open drain
    output logic            fault_pin_n_out,
    output logic            fault_pin_n_oe_out,
    // device state inputs
    input  wire logic       sleep_entry_in,
    input  wire logic       supply_lockout_in,
    input  wire gds_fault_t fault_in,
    // configuration towards the gate drive
    output gds_cfg_t        cfg_out
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [10:0] read_sel(input gds_map_t m,
                                             input logic [3:0] a);
        logic [10:0] r;
        r = 11'h000;
        if (!a[3]) begin
            r = m[a[2:0]];
        end
        return r;
    endfunction : read_sel

    function automatic gds_map_t build_map(input logic [10:0] p,
                                           input logic [10:0] s,
                                           input gds_cfg_t c);
        gds_map_t m;
        m = '0;
        m[`GDS_ADDR_STAT1] = p;
        m[`GDS_ADDR_STAT2] = s;
        m[`GDS_ADDR_DRV]   = c.driver_control;
        m[`GDS_ADDR_HS]    = c.high_side_drive_strength;
        m[`GDS_ADDR_LS]    = c.low_side_drive_strength;
        m[`GDS_ADDR_OCP]   = c.overcurrent_protection_control;
        if (HAS_SENSE_AMP) begin
            m[`GDS_ADDR_CSA] = c.sense_amplifier_control;
        end
        return m;
    endfunction : build_map

    gds_rx_t   rx_ff;
    gds_rx_t   nxt_rx;
    gds_hold_t hold_ff;
    gds_hold_t nxt_hold;
    gds_tx_t   tx_ff;
    gds_tx_t   nxt_tx;
    gds_sys_t  sys_ff;
    gds_sys_t  nxt_sys;
    logic      link_rst_n;

    // select high holds rx_ff and tx_ff cleared, not hold_ff; sclk is low at both
    // select edges, so release never races a clock edge
    assign link_rst_n = arst_n_in & ~chip_select_n_in;

    ////////////////////////////////////////////////////////////////////////
    // link domain, falling edge: capture

    always_comb begin
        nxt_rx   = rx_ff;
        nxt_hold = hold_ff;
        nxt_rx.shift = {rx_ff.shift[14:0], serial_in_in};
        if (rx_ff.cnt != 5'(`GDS_WORD_BITS + 1)) begin
            nxt_rx.cnt = rx_ff.cnt + 5'h01;
        end
        if (rx_ff.cnt == 5'(`GDS_WORD_BITS - 1)) begin
            nxt_hold.word     = nxt_rx.shift;
            nxt_hold.done_tgl = ~hold_ff.done_tgl;
        end
        // a 17th bit marks the frame as too long
        if (rx_ff.cnt == 5'(`GDS_WORD_BITS)) begin
            nxt_hold.err_tgl = ~hold_ff.err_tgl;
        end
    end

    always_ff @(negedge serial_clk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rx_ff <= '0;
        end else begin
            rx_ff <= nxt_rx;
        end
    end

    always_ff @(negedge serial_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hold_ff <= '0;
        end else begin
            hold_ff <= nxt_hold;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link domain, rising edge: launch

    // the snapshot was taken at select fall and stays still for the whole
    // frame, so the link may read it without further synchronising
    always_comb begin
        nxt_tx = tx_ff;
        if (tx_ff.cnt != 5'(`GDS_WORD_BITS)) begin
            nxt_tx.cnt = tx_ff.cnt + 5'h01;
        end
        if (tx_ff.cnt < 5'(`GDS_DONT_CARE)) begin
            nxt_tx.sout = 1'b0;
        end else if (tx_ff.cnt == 5'(`GDS_DONT_CARE)) begin
            // address bits are complete after the fifth falling edge
            nxt_tx.data = read_sel(sys_ff.snap, rx_ff.shift[3:0]);
            nxt_tx.sout = nxt_tx.data[10];
            nxt_tx.data = {nxt_tx.data[9:0], 1'b0};
        end else begin
            nxt_tx.sout = tx_ff.data[10];
            nxt_tx.data = {tx_ff.data[9:0], 1'b0};
        end
    end

    always_ff @(posedge serial_clk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_ff <= '0;
        end else begin
            tx_ff <= nxt_tx;
        end
    end

    assign serial_out_out    = tx_ff.sout;
    assign serial_out_oe_out = ~chip_select_n_in;

    ////////////////////////////////////////////////////////////////////////
    // system domain

    logic        cs_rise;
    logic        cs_fall;
    logic        frame_ok;
    logic        wr_en;
    logic        locked;
    logic        clear_latched_faults;
    logic        soft_rst;
    logic [3:0]  wr_addr;
    logic [10:0] wr_data;
    logic [10:0] prim_set;
    logic [10:0] sec_set;
    gds_fault_t  f;

    always_comb begin
        nxt_sys = sys_ff;
        f       = sys_ff.flt_sync2;
        nxt_sys.cs_sync      = {sys_ff.cs_sync[0], chip_select_n_in};
        nxt_sys.cs_prev      = sys_ff.cs_sync[1];
        nxt_sys.done_sync    = {sys_ff.done_sync[0], hold_ff.done_tgl};
        nxt_sys.err_sync     = {sys_ff.err_sync[0], hold_ff.err_tgl};
        nxt_sys.sleep_sync   = {sys_ff.sleep_sync[0], sleep_entry_in};
        nxt_sys.lockout_sync = {sys_ff.lockout_sync[0], supply_lockout_in};
        nxt_sys.flt_sync1    = fault_in;
        nxt_sys.flt_sync2    = sys_ff.flt_sync1;

        cs_rise = sys_ff.cs_sync[1] & ~sys_ff.cs_prev;
        cs_fall = ~sys_ff.cs_sync[1] & sys_ff.cs_prev;
        // the last falling edge is half a clock before select rises, so
        // its toggles have crossed by the time the rise is seen
        frame_ok = cs_rise
                 & (sys_ff.done_sync[1] != sys_ff.done_seen)
                 & (sys_ff.err_sync[1] == sys_ff.err_seen);
        if (cs_rise) begin
            nxt_sys.done_seen = sys_ff.done_sync[1];
            nxt_sys.err_seen  = sys_ff.err_sync[1];
        end

        wr_en   = frame_ok & ~hold_ff.word[`GDS_RW_BIT];
        wr_addr = hold_ff.word[`GDS_ADDR_MSB:`GDS_ADDR_LSB];
        wr_data = hold_ff.word[`GDS_DATA_W-1:0];
        locked  = sys_ff.cfg.high_side_drive_strength
                      [`GDS_LOCK_MSB:`GDS_LOCK_LSB] == `GDS_LOCK_ON;
        clear_latched_faults = 1'b0;

        if (wr_en) begin
            case (wr_addr)
                `GDS_ADDR_DRV: begin
                    clear_latched_faults = wr_data[`GDS_CLR_BIT];
                    if (locked) begin
                        nxt_sys.cfg.driver_control =
                            (sys_ff.cfg.driver_control
                             & ~`GDS_DRV_LOCK_MASK)
                            | (wr_data & `GDS_DRV_LOCK_MASK);
                    end else begin
                        // clear bit self-resets, bit 10 stays zero
                        nxt_sys.cfg.driver_control =
                            wr_data & `GDS_DRV_WR_MASK;
                    end
                end
                `GDS_ADDR_HS: begin
                    if (locked) begin
                        if (wr_data[`GDS_LOCK_MSB:`GDS_LOCK_LSB]
                            == `GDS_LOCK_OFF) begin
                            nxt_sys.cfg.high_side_drive_strength
                                [`GDS_LOCK_MSB:`GDS_LOCK_LSB] =
                                `GDS_LOCK_OFF;
                        end
                    end else begin
                        nxt_sys.cfg.high_side_drive_strength[7:0] =
                            wr_data[7:0];
                        if (wr_data[`GDS_LOCK_MSB:`GDS_LOCK_LSB]
                            == `GDS_LOCK_ON) begin
                            nxt_sys.cfg.high_side_drive_strength
                                [`GDS_LOCK_MSB:`GDS_LOCK_LSB] =
                                `GDS_LOCK_ON;
                        end
                    end
                end
                `GDS_ADDR_LS: begin
                    if (!locked) begin
                        nxt_sys.cfg.low_side_drive_strength = wr_data;
                    end
                end
                `GDS_ADDR_OCP: begin
                    if (!locked) begin
                        nxt_sys.cfg.overcurrent_protection_control =
                            wr_data;
                    end
                end
                `GDS_ADDR_CSA: begin
                    if (!locked && HAS_SENSE_AMP) begin
                        nxt_sys.cfg.sense_amplifier_control = wr_data;
                    end
                end
                // status, reserved and unlisted addresses ignore writes
                default: begin
                    nxt_sys.cfg = sys_ff.cfg;
                end
            endcase
        end

        soft_rst = sys_ff.sleep_sync[1] | sys_ff.lockout_sync[1];
        if (soft_rst) begin
            nxt_sys.cfg.driver_control                 = `GDS_RST_DRV;
            nxt_sys.cfg.high_side_drive_strength       = `GDS_RST_HS;
            nxt_sys.cfg.low_side_drive_strength        = `GDS_RST_LS;
            nxt_sys.cfg.overcurrent_protection_control = `GDS_RST_OCP;
            nxt_sys.cfg.sense_amplifier_control        = `GDS_RST_CSA;
        end

        // fault latches: a condition present in the clearing cycle wins
        prim_set = {1'b0, f.drain_source_overcurrent, f.gate_drive_fault,
                    f.supply_lockout_fault | sys_ff.lockout_sync[1],
                    f.overtemp_shutdown,
                    f.phase_overcurrent};
        sec_set  = {f.amp_overcurrent & {3{HAS_SENSE_AMP}},
                    f.overtemp_warning, f.pump_undervoltage,
                    f.gate_switch_fault};
        nxt_sys.prim = ((clear_latched_faults | soft_rst) ? `GDS_RST_STAT : sys_ff.prim)
                     | prim_set;
        nxt_sys.sec  = ((clear_latched_faults | soft_rst) ? `GDS_RST_STAT : sys_ff.sec)
                     | sec_set;
        nxt_sys.prim[`GDS_FAULT_BIT] = (|nxt_sys.prim[9:0])
            | (|nxt_sys.sec[10:8]) | nxt_sys.sec[6]
            | (nxt_sys.sec[7]
               & sys_ff.cfg.driver_control[`GDS_OTW_REP_BIT]);

        // freeze the readable map for the frame now starting
        if (cs_fall) begin
            nxt_sys.snap = build_map(sys_ff.prim, sys_ff.sec,
                                     sys_ff.cfg);
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sys_ff <= '0;
            sys_ff.cs_sync <= 2'h3;
            sys_ff.cs_prev <= 1'b1;
            sys_ff.prim <= `GDS_RST_STAT;
            sys_ff.sec  <= `GDS_RST_STAT;
            sys_ff.cfg.driver_control                 <= `GDS_RST_DRV;
            sys_ff.cfg.high_side_drive_strength       <= `GDS_RST_HS;
            sys_ff.cfg.low_side_drive_strength        <= `GDS_RST_LS;
            sys_ff.cfg.overcurrent_protection_control <= `GDS_RST_OCP;
            sys_ff.cfg.sense_amplifier_control        <= `GDS_RST_CSA;
        end else begin
            sys_ff <= nxt_sys;
        end
    end

    // pin and bit 10 come from the same flop, so they always agree
    assign fault_pin_n_out    = 1'b0;
    assign fault_pin_n_oe_out = sys_ff.prim[`GDS_FAULT_BIT];
    assign cfg_out            = sys_ff.cfg;

endmodule : gds_spi_regs

// >>> rtl/gds_params.svh
`ifndef GDS_PARAMS_SVH
`define GDS_PARAMS_SVH
// Overview of operation
// - power up and sleep entry return registers to defaults; supply lockout does too but sets primary bit 7
// - input word: bit 15 read/write, bits 14:11 address, bits 10:0 data
// - write frame (flag 0) shifts out the value held before the write
// - read frame (flag 1) shifts out the register unchanged
// - output word is 16 bits, five don't-care bits then eleven data bits
// - reserved bits reset to zero and stay zero
// - both status registers are read-only; writes leave them unchanged
// - primary status at address 0, every field defaults to zero
// - primary bit 10 is the OR of bits 9:0, secondary 10:8 and 6, secondary 7 if 0x2 bit 7 set; mirrors the fault pin
// - primary bit 9 drain-source overcurrent, bit 8 gate drive fault
// - primary bit 7 supply lockout fault, bit 6 overtemperature shutdown
// - primary bits 5:0 per-switch overcurrent, A high first, C low last
// - secondary status sits at address 1 and is read-only
// - sample input on falling edge, launch output on rising, MSB first
// - frames with other than 16 clocks are errors and are discarded
// - lock code 110b blocks writes except lock field and bits 2:0 of 0x2
// - secondary: amp overcurrent 10:8, warning 7, pump 6, gate faults 5:0

// serial word layout
`define GDS_WORD_BITS     16
`define GDS_RW_BIT        15
`define GDS_ADDR_MSB      14
`define GDS_ADDR_LSB      11
`define GDS_DATA_W        11
`define GDS_DONT_CARE     5

// register addresses
`define GDS_ADDR_STAT1    4'h0
`define GDS_ADDR_STAT2    4'h1
`define GDS_ADDR_DRV      4'h2
`define GDS_ADDR_HS       4'h3
`define GDS_ADDR_LS       4'h4
`define GDS_ADDR_OCP      4'h5
`define GDS_ADDR_CSA      4'h6

// fields
`define GDS_LOCK_MSB      10
`define GDS_LOCK_LSB      8
`define GDS_LOCK_ON       3'h6
`define GDS_LOCK_OFF      3'h3
`define GDS_CLR_BIT       0
`define GDS_OTW_REP_BIT   7
`define GDS_FAULT_BIT     10
`define GDS_DRV_WR_MASK   11'h3FE
`define GDS_DRV_LOCK_MASK 11'h006

// reset values
`define GDS_RST_STAT      11'h000
`define GDS_RST_DRV       11'h000
`define GDS_RST_HS        11'h3FF
`define GDS_RST_LS        11'h700
`define GDS_RST_OCP       11'h000
`define GDS_RST_CSA       11'h000

`endif

// >>> rtl/gds_pkg.sv
package gds_pkg;

    // fault condition levels from the analog protection blocks
    typedef struct packed {
        logic       drain_source_overcurrent;
        logic       gate_drive_fault;
        logic       supply_lockout_fault;
        logic       overtemp_shutdown;
        logic [5:0] phase_overcurrent;  // a high, a low, ... c low
        logic [2:0] amp_overcurrent;    // amp a, b, c
        logic       overtemp_warning;
        logic       pump_undervoltage;
        logic [5:0] gate_switch_fault;  // a high, a low, ... c low
    } gds_fault_t;

    typedef struct packed {
        logic [10:0] driver_control;
        logic [10:0] high_side_drive_strength;
        logic [10:0] low_side_drive_strength;
        logic [10:0] overcurrent_protection_control;
        logic [10:0] sense_amplifier_control;
    } gds_cfg_t;

    typedef logic [7:0][10:0] gds_map_t;

    // falling-edge capture, cleared while select is high
    typedef struct packed {
        logic [15:0] shift;
        logic [4:0]  cnt;
    } gds_rx_t;

    // falling-edge results that must outlive the frame
    typedef struct packed {
        logic [15:0] word;
        logic        done_tgl;
        logic        err_tgl;
    } gds_hold_t;

    // rising-edge launch, cleared while select is high
    typedef struct packed {
        logic [4:0]  cnt;
        logic [10:0] data;
        logic        sout;
    } gds_tx_t;

    typedef struct packed {
        logic [1:0]  cs_sync;
        logic        cs_prev;
        logic [1:0]  done_sync;
        logic        done_seen;
        logic [1:0]  err_sync;
        logic        err_seen;
        logic [1:0]  sleep_sync;
        logic [1:0]  lockout_sync;
        gds_fault_t  flt_sync1;
        gds_fault_t  flt_sync2;
        logic [10:0] prim;
        logic [10:0] sec;
        gds_cfg_t    cfg;
        gds_map_t    snap;
    } gds_sys_t;

endpackage : gds_pkg

// >>> test/gds_spi_regs_chk.sv
`timescale 1ns/1ps
module gds_spi_regs_chk
    import gds_pkg::*;
(
    // clock and reset
    input wire logic       clk_sys_in,
    input wire logic       arst_n_in,
    // serial link
    input wire logic       serial_clk_in,
    input wire logic       chip_select_n_in,
    input wire logic       serial_out_out,
    input wire logic       serial_out_oe_out,
    // fault pin and device state
    input wire logic       fault_pin_n_oe_out,
    input wire logic       sleep_entry_in,
    input wire logic       supply_lockout_in,
    input wire gds_fault_t fault_in,
    input wire gds_cfg_t   cfg_out
);
    localparam gds_cfg_t CFG_DEF =
        {11'h000, 11'h3FF, 11'h700, 11'h000, 11'h000};
    logic [4:0] fall_cnt_ff;

    // falling link edges so far in this frame
    always_ff @(negedge serial_clk_in or posedge chip_select_n_in) begin
        if (chip_select_n_in) begin
            fall_cnt_ff <= 5'h00;
        end else begin
            fall_cnt_ff <= fall_cnt_ff + 5'h01;
        end
    end

    sequence s_lockout_held;
        $rose(supply_lockout_in) ##1 supply_lockout_in [*4];
    endsequence

    ////////////////////////////////////////////////////////////////////////
    chk_oe_follows_sel: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in) serial_out_oe_out == !chip_select_n_in)
        else $error("data enable off select");
    chk_lead_bits_zero: assert property (@(negedge serial_clk_in)
        disable iff (!arst_n_in)
        !chip_select_n_in && fall_cnt_ff < 5'h05 |-> !serial_out_out)
        else $error("lead output bit not zero");
    chk_fault_to_pin: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        $rose(fault_in.drain_source_overcurrent) |-> ##[1:6] fault_pin_n_oe_out)
        else $error("fault pin not pulled");
    chk_pin_held_frame: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        !chip_select_n_in && fault_pin_n_oe_out |=> fault_pin_n_oe_out)
        else $error("fault pin released in frame");
    chk_cfg_held_frame: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in) !chip_select_n_in [*2] |-> $stable(cfg_out))
        else $error("config changed in frame");
    chk_sleep_defaults: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in) sleep_entry_in [*5] |-> cfg_out == CFG_DEF)
        else $error("sleep left config set");
    chk_lockout_defaults: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in) s_lockout_held |-> cfg_out == CFG_DEF)
        else $error("lockout left config set");
    chk_reset_values: assert property (@(posedge clk_sys_in)
        disable iff (!arst_n_in)
        $rose(arst_n_in) |-> cfg_out == CFG_DEF && !fault_pin_n_oe_out)
        else $error("wrong state after reset");
endmodule : gds_spi_regs_chk

// >>> test/gds_master_model.sv
`timescale 1ns/1ps
module gds_master_model (
    // serial link
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      sdi_out,
    input  wire logic sdo_in
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // n other than 16 gives a frame the device has to drop
    task automatic xfer(input logic [15:0] w, input int n,
                        output logic [15:0] r);
        r = 16'h0000;
        cs_n_out = 1'b0;
        #40;
        for (int i = 0; i < n; i++) begin
            sclk_out = 1'b1;
            #1 sdi_out = w[15 - (i % 16)];
            #31 sclk_out = 1'b0;
            r = {r[14:0], sdo_in};
            #32;
        end
        cs_n_out = 1'b1;
        // released line must not keep its last level
        sdi_out = ~sdi_out;
        #400;
    endtask : xfer
endmodule : gds_master_model

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench
    import gds_pkg::*;
;
    localparam gds_cfg_t CFG_DEF =
        {11'h000, 11'h3FF, 11'h700, 11'h000, 11'h000};
    logic        clk_sys_in, arst_n_in, serial_clk_in, chip_select_n_in;
    logic        serial_in_in, serial_out_out, serial_out_oe_out;
    logic        fault_pin_n_out, fault_pin_n_oe_out;
    logic        sleep_entry_in, supply_lockout_in;
    gds_fault_t  fault_in;
    gds_cfg_t    cfg_out;
    logic [15:0] resp;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          cyc = 0;
    logic [10:0] dflt [8] = '{11'h000, 11'h000, 11'h000, 11'h3FF,
                              11'h700, 11'h000, 11'h000, 11'h000};
    logic [3:0]  rsv [4] = '{4'h0, 4'h1, 4'h7, 4'hF};

    gds_spi_regs gds_spi_regs_inst (
        .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .serial_clk_in(serial_clk_in), .chip_select_n_in(chip_select_n_in),
        .serial_in_in(serial_in_in), .serial_out_out(serial_out_out),
        .serial_out_oe_out(serial_out_oe_out),
        .fault_pin_n_out(fault_pin_n_out),
        .fault_pin_n_oe_out(fault_pin_n_oe_out),
        .sleep_entry_in(sleep_entry_in),
        .supply_lockout_in(supply_lockout_in),
        .fault_in(fault_in), .cfg_out(cfg_out));
    gds_master_model gds_master_model_inst (
        .sclk_out(serial_clk_in), .cs_n_out(chip_select_n_in),
        .sdi_out(serial_in_in), .sdo_in(serial_out_out));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [54:0] seen, input logic [54:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : wait_clk

    // start off the clock edge so select never races the synchronisers
    task automatic frame(input logic [15:0] w, input int n);
        @(posedge clk_sys_in);
        #0.2;
        gds_master_model_inst.xfer(w, n, resp);
    endtask : frame

    task automatic xfer_chk(input logic [15:0] w, input logic [10:0] exp);
        frame(w, 16);
        check(resp, {5'h00, exp});
    endtask : xfer_chk

    task automatic rd(input logic [3:0] a, input logic [10:0] exp);
        xfer_chk({1'b1, a, 11'h000}, exp);
    endtask : rd

    task automatic wr(input logic [3:0] a, input logic [10:0] d,
                      input logic [10:0] old);
        xfer_chk({1'b0, a, d}, old);
    endtask : wr

    task automatic soft_rst(input bit lockout);
        @(posedge clk_sys_in);
        if (lockout) begin
            supply_lockout_in <= 1'b1;
        end else begin
            sleep_entry_in <= 1'b1;
        end
        wait_clk(10);
        check(cfg_out, CFG_DEF);
        supply_lockout_in <= 1'b0;
        sleep_entry_in <= 1'b0;
        wait_clk(4);
    endtask : soft_rst

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    // about 45 frames of 300 cycles each are expected
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            end_of_test();
        end
    end

    initial begin
        arst_n_in = 1'b0;
        sleep_entry_in = 1'b0;
        supply_lockout_in = 1'b0;
        fault_in = '0;
        wait_clk(16);
        arst_n_in <= 1'b1;
        wait_clk(4);
        check(cfg_out, CFG_DEF);
        for (int a = 0; a < 8; a++) begin
            rd(4'(a), dflt[a]);
        end
        wr(4'h5, 11'h2AA, 11'h000);
        rd(4'h5, 11'h2AA);
        wr(4'h5, 11'h155, 11'h2AA);
        rd(4'h5, 11'h155);
        check(cfg_out.overcurrent_protection_control, 11'h155);
        foreach (rsv[i]) begin
            wr(rsv[i], 11'h7FF, 11'h000);
            rd(rsv[i], 11'h000);
        end
        frame({1'b0, 4'h4, 11'h0AB}, 15);
        frame({1'b0, 4'h4, 11'h0AB}, 17);
        rd(4'h4, 11'h700);
        wr(4'h3, 11'h6FF, 11'h3FF);
        wr(4'h5, 11'h011, 11'h155);
        wr(4'h3, 11'h5FF, 11'h6FF);
        wr(4'h2, 11'h086, 11'h000);
        rd(4'h5, 11'h155);
        rd(4'h2, 11'h006);
        wr(4'h3, 11'h3FF, 11'h6FF);
        wr(4'h5, 11'h011, 11'h155);
        wr(4'h3, 11'h512, 11'h3FF);
        rd(4'h3, 11'h312);
        @(posedge clk_sys_in);
        fault_in <= 21'h1B0D52;
        wait_clk(8);
        check(fault_pin_n_oe_out, 1'b1);
        check(fault_pin_n_out, 1'b0);
        fault_in <= '0;
        wait_clk(8);
        rd(4'h0, 11'h761);
        rd(4'h1, 11'h552);
        check(fault_pin_n_oe_out, 1'b1);
        wr(4'h2, 11'h001, 11'h006);
        rd(4'h0, 11'h000);
        check(fault_pin_n_oe_out, 1'b0);
        wr(4'h4, 11'h0AB, 11'h700);
        soft_rst(1'b1);
        rd(4'h4, 11'h700);
        rd(4'h0, 11'h480);
        check(fault_pin_n_oe_out, 1'b1);
        wr(4'h4, 11'h0AB, 11'h700);
        soft_rst(1'b0);
        rd(4'h0, 11'h000);
        end_of_test();
    end
endmodule : testbench

bind gds_spi_regs gds_spi_regs_chk gds_spi_regs_chk_inst (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .serial_clk_in(serial_clk_in), .chip_select_n_in(chip_select_n_in),
    .serial_out_out(serial_out_out), .serial_out_oe_out(serial_out_oe_out),
    .fault_pin_n_oe_out(fault_pin_n_oe_out),
    .sleep_entry_in(sleep_entry_in), .supply_lockout_in(supply_lockout_in),
    .fault_in(fault_in), .cfg_out(cfg_out));
